// ==== rtl/transceiver_pma_pcs_control_regs.sv ====
// control and status register bank of a multi-channel transceiver phy
//
// Overview of operation
// - writing one to a loopback bit loops that channel's serial data back
// - signal-present register shows per channel that input voltage is sensed
// - lock-to-data request bit makes that channel's recovery loop lock to data
// - lock-to-reference request bit makes the recovery loop lock to reference clock
// - locked-to-data status bit reads one once the loop locks to data
// - locked-to-reference status bit reads one while locked to reference; read only
// - lane selector holds the index that every coding-sublayer access uses
// - selector means group number when bonded, lane number when not bonded
// - five-bit read field shows bits slipped by the receive word aligner
// - read bit shows receive phase-compensation fifo error of selected lane
// - read-write bit shows transmit phase-compensation fifo error of selected lane
// - five-bit field sets transmit bit-slip amount of selected lane
// - transmit polarity bit inverts every transmitted bit of selected lane
// - receive polarity bit inverts every received bit ahead of the decoder
// - each zero-to-one write of receive slip bit slips exactly one bit
// - byte-order bit swaps byte order in each received word
// - bit-order bit reverses bit order in each received word
// - alignment enable bit starts pattern search in manual alignment mode
// - one reconfiguration port per channel and per transmit pll, on clk
// - device returns forty-six output bits from each port
// - word-addressed registers in one address space for a 32-bit host
// - after reset each loop runs in automatic lock mode until a request bit
`timescale 1ns/1ns
`include "xcvr_ctrl_defines.svh"
module transceiver_pma_pcs_control_regs
  import xcvr_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                resetn,
  // management bus
  input  wire logic [`ADDR_W-1:0]                  mgmt_address,
  input  wire logic                                mgmt_read,
  input  wire logic                                mgmt_write,
  input  wire logic [`DATA_W-1:0]                  mgmt_writedata,
  output      logic [`DATA_W-1:0]                  mgmt_readdata,
  output      logic                                mgmt_waitrequest,
  // status from the transceiver channels
  input  wire logic [`NUM_CH-1:0]                  rx_signal_present_in,
  input  wire logic [`NUM_CH-1:0]                  cdr_locked_data_in,
  input  wire logic [`NUM_CH-1:0]                  cdr_locked_reference_in,
  input  wire logic [`NUM_CH*`SLIP_W-1:0]          rx_slipped_in,
  input  wire logic [`NUM_CH-1:0]                  rx_fifo_error_in,
  input  wire logic [`NUM_CH-1:0]                  tx_fifo_error_in,
  // controls to the transceiver channels
  output      logic [`NUM_CH-1:0]                  serial_loopback,
  output      logic [`NUM_CH-1:0]                  cdr_lock_data,
  output      logic [`NUM_CH-1:0]                  cdr_lock_reference,
  output      logic [`NUM_CH-1:0]                  cdr_auto_mode,
  output      logic [`NUM_CH*`SLIP_W-1:0]          tx_slip_count,
  output      logic [`NUM_CH-1:0]                  tx_invert,
  output      logic [`NUM_CH-1:0]                  rx_invert,
  output      logic [`NUM_CH-1:0]                  rx_slip_pulse,
  output      logic [`NUM_CH-1:0]                  rx_byte_reverse,
  output      logic [`NUM_CH-1:0]                  rx_bit_reverse,
  output      logic [`NUM_CH-1:0]                  rx_align_enable,
  // reconfiguration ports
  input  wire logic [`NUM_RECFG*`RECFG_IN_W-1:0]   reconfig_bus_in,
  output      logic [`NUM_RECFG*`RECFG_OUT_W-1:0]  reconfig_bus_out
);

  state_t q;
  state_t d;

  // bonded variants form one group of all lanes, so group 0 hits every lane
  function automatic logic lane_hit(input logic [`DATA_W-1:0] sel, input int lane);
    logic hit;
    if (`BONDED) begin
      hit = (sel == '0);
    end else begin
      hit = (sel == `DATA_W'(lane));
    end
    return hit;
  endfunction : lane_hit

  // index of the lane whose status a read returns
  function automatic int read_lane(input logic [`DATA_W-1:0] sel);
    int idx;
    idx = -1;
    for (int i = 0; i < `NUM_CH; i++) begin
      if (lane_hit(sel, i) && idx < 0) begin
        idx = i;
      end
    end
    return idx;
  endfunction : read_lane

  logic                 wr_en;
  logic                 rd_en;
  logic [`DATA_W-1:0]   rd_val;
  int                   rl;
  pin_status_t          pins;

  // a write arriving together with a read is refused until the read ends
  assign wr_en = mgmt_write & ~mgmt_read;
  // first read cycle waits, second one returns the registered word
  assign rd_en = mgmt_read & ~q.rack;

  always_comb begin
    pins.signal_present = rx_signal_present_in;
    pins.locked_data    = cdr_locked_data_in;
    pins.locked_ref     = cdr_locked_reference_in;
    for (int i = 0; i < `NUM_CH; i++) begin
      pins.rx_slipped[i] = rx_slipped_in[i*`SLIP_W +: `SLIP_W];
    end
    pins.rx_fifo_error  = rx_fifo_error_in;
    pins.tx_fifo_error  = tx_fifo_error_in;
  end

  always_comb begin
    rl     = read_lane(q.lane_sel);
    rd_val = '0;
    unique case (mgmt_address)
      `OFS_LOOPBACK:    rd_val[`NUM_CH-1:0] = q.loopback;
      `OFS_SIG_PRESENT: rd_val[`NUM_CH-1:0] = q.sync2.signal_present;
      `OFS_LTD_REQ:     rd_val[`NUM_CH-1:0] = q.lock_data_req;
      `OFS_LTR_REQ:     rd_val[`NUM_CH-1:0] = q.lock_ref_req;
      `OFS_LTD_STAT:    rd_val[`NUM_CH-1:0] = q.sync2.locked_data;
      `OFS_LTR_STAT:    rd_val[`NUM_CH-1:0] = q.sync2.locked_ref;
      `OFS_LANE_SEL:    rd_val = q.lane_sel;
      `OFS_RX_ALIGN: begin
        if (rl >= 0) begin
          rd_val[`SLIP_MSB:`SLIP_LSB] = q.sync2.rx_slipped[rl];
          rd_val[`BIT_FIFO_ERR]       = q.sync2.rx_fifo_error[rl];
        end
      end
      `OFS_TX_FIFO: begin
        if (rl >= 0) begin
          rd_val[`BIT_FIFO_ERR] = q.lane[rl].tx_fifo_error;
        end
      end
      `OFS_TX_CTRL: begin
        if (rl >= 0) begin
          rd_val[`SLIP_MSB:`SLIP_LSB] = q.lane[rl].tx_slip;
          rd_val[`BIT_TX_POL]         = q.lane[rl].tx_invert;
        end
      end
      `OFS_RX_POL: begin
        if (rl >= 0) begin
          rd_val[`BIT_RX_POL] = q.lane[rl].rx_invert;
        end
      end
      `OFS_RX_ORDER: begin
        if (rl >= 0) begin
          rd_val[`BIT_RX_SLIP]  = q.lane[rl].rx_slip_level;
          rd_val[`BIT_BYTE_REV] = q.lane[rl].rx_byte_reverse;
          rd_val[`BIT_BIT_REV]  = q.lane[rl].rx_bit_reverse;
          rd_val[`BIT_ALIGN_EN] = q.lane[rl].rx_align_enable;
        end
      end
      default: rd_val = '0; // unmapped words read zero
    endcase
  end

  always_comb begin
    d = q;
    // pins pass two flops before any logic reads them
    d.sync1 = pins;
    d.sync2 = q.sync1;
    d.slip_pulse = '0;
    d.rack  = rd_en;
    if (rd_en) begin
      d.rdata = rd_val;
    end
    for (int i = 0; i < `NUM_CH; i++) begin
      // sticky error: a set in the clearing cycle wins
      if (wr_en && mgmt_address == `OFS_TX_FIFO && lane_hit(q.lane_sel, i)
          && mgmt_writedata[`BIT_FIFO_ERR]) begin
        d.lane[i].tx_fifo_error = 1'b0;
      end
      if (q.sync2.tx_fifo_error[i]) begin
        d.lane[i].tx_fifo_error = 1'b1;
      end
    end
    if (wr_en) begin
      unique case (mgmt_address)
        `OFS_LOOPBACK: d.loopback      = mgmt_writedata[`NUM_CH-1:0];
        `OFS_LTD_REQ:  d.lock_data_req = mgmt_writedata[`NUM_CH-1:0];
        `OFS_LTR_REQ:  d.lock_ref_req  = mgmt_writedata[`NUM_CH-1:0];
        `OFS_LANE_SEL: d.lane_sel      = mgmt_writedata;
        `OFS_TX_CTRL: begin
          for (int i = 0; i < `NUM_CH; i++) begin
            if (lane_hit(q.lane_sel, i)) begin
              d.lane[i].tx_slip   = mgmt_writedata[`SLIP_MSB:`SLIP_LSB];
              d.lane[i].tx_invert = mgmt_writedata[`BIT_TX_POL];
            end
          end
        end
        `OFS_RX_POL: begin
          for (int i = 0; i < `NUM_CH; i++) begin
            if (lane_hit(q.lane_sel, i)) begin
              d.lane[i].rx_invert = mgmt_writedata[`BIT_RX_POL];
            end
          end
        end
        `OFS_RX_ORDER: begin
          for (int i = 0; i < `NUM_CH; i++) begin
            if (lane_hit(q.lane_sel, i)) begin
              // only a rising write slips; holding one slips no more
              d.slip_pulse[i] = mgmt_writedata[`BIT_RX_SLIP]
                                & ~q.lane[i].rx_slip_level;
              d.lane[i].rx_slip_level   = mgmt_writedata[`BIT_RX_SLIP];
              d.lane[i].rx_byte_reverse = mgmt_writedata[`BIT_BYTE_REV];
              d.lane[i].rx_bit_reverse  = mgmt_writedata[`BIT_BIT_REV];
              d.lane[i].rx_align_enable = mgmt_writedata[`BIT_ALIGN_EN];
            end
          end
        end
        // status words and unmapped words ignore writes
        default: d.lane_sel = q.lane_sel;
      endcase
    end
    // each port answers with a registered copy of its own low inputs
    for (int p = 0; p < `NUM_RECFG; p++) begin
      d.recfg_out[p*`RECFG_OUT_W +: `RECFG_OUT_W] =
        reconfig_bus_in[p*`RECFG_IN_W +: `RECFG_OUT_W];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0; // request bits clear: loops start in automatic mode
    end else begin
      q <= d;
    end
  end

  assign mgmt_waitrequest   = rd_en;
  assign mgmt_readdata      = q.rdata;
  assign serial_loopback    = q.loopback;
  assign cdr_lock_data      = q.lock_data_req;
  assign cdr_lock_reference = q.lock_ref_req;
  assign cdr_auto_mode      = ~(q.lock_data_req | q.lock_ref_req);
  assign rx_slip_pulse      = q.slip_pulse;
  assign reconfig_bus_out   = q.recfg_out;

  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g++) begin : g_lane
      assign tx_slip_count[g*`SLIP_W +: `SLIP_W] = q.lane[g].tx_slip;
      assign tx_invert[g]       = q.lane[g].tx_invert;
      assign rx_invert[g]       = q.lane[g].rx_invert;
      assign rx_byte_reverse[g] = q.lane[g].rx_byte_reverse;
      assign rx_bit_reverse[g]  = q.lane[g].rx_bit_reverse;
      assign rx_align_enable[g] = q.lane[g].rx_align_enable;
    end
  endgenerate

endmodule : transceiver_pma_pcs_control_regs

// ==== rtl/xcvr_ctrl_defines.svh ====
// register map, field positions and sizes of the transceiver control bank
`ifndef XCVR_CTRL_DEFINES_SVH
`define XCVR_CTRL_DEFINES_SVH
`define NUM_CH            4
`define NUM_PLL           1
`define NUM_RECFG         (`NUM_CH + `NUM_PLL)
`define RECFG_IN_W        70
`define RECFG_OUT_W       46
`define BONDED            1'b0
`define ADDR_W            9
`define DATA_W            32
`define SLIP_W            5
`define OFS_LOOPBACK      9'h061
`define OFS_SIG_PRESENT   9'h063
`define OFS_LTD_REQ       9'h064
`define OFS_LTR_REQ       9'h065
`define OFS_LTD_STAT      9'h066
`define OFS_LTR_STAT      9'h067
`define OFS_LANE_SEL      9'h080
`define OFS_RX_ALIGN      9'h081
`define OFS_TX_FIFO       9'h082
`define OFS_TX_CTRL       9'h083
`define OFS_RX_POL        9'h084
`define OFS_RX_ORDER      9'h085
`define BIT_FIFO_ERR      0
`define BIT_TX_POL        0
`define BIT_RX_POL        0
`define BIT_ALIGN_EN      0
`define BIT_BIT_REV       1
`define BIT_BYTE_REV      2
`define BIT_RX_SLIP       3
`define SLIP_LSB          1
`define SLIP_MSB          5
`endif

// ==== rtl/xcvr_ctrl_pkg.sv ====
// types of the transceiver control bank
`include "xcvr_ctrl_defines.svh"
package xcvr_ctrl_pkg;
  typedef logic [`NUM_CH-1:0] ch_vec_t;
  typedef logic [`SLIP_W-1:0] slip_t;

  typedef struct packed {
    slip_t tx_slip;
    logic  tx_invert;
    logic  rx_invert;
    logic  rx_slip_level;
    logic  rx_byte_reverse;
    logic  rx_bit_reverse;
    logic  rx_align_enable;
    logic  tx_fifo_error;
  } lane_ctl_t;

  typedef struct packed {
    ch_vec_t                 signal_present;
    ch_vec_t                 locked_data;
    ch_vec_t                 locked_ref;
    slip_t [`NUM_CH-1:0]     rx_slipped;
    ch_vec_t                 rx_fifo_error;
    ch_vec_t                 tx_fifo_error;
  } pin_status_t;

  typedef struct packed {
    ch_vec_t                              loopback;
    ch_vec_t                              lock_data_req;
    ch_vec_t                              lock_ref_req;
    logic [`DATA_W-1:0]                   lane_sel;
    lane_ctl_t [`NUM_CH-1:0]              lane;
    ch_vec_t                              slip_pulse;
    pin_status_t                          sync1;
    pin_status_t                          sync2;
    logic [`DATA_W-1:0]                   rdata;
    logic                                 rack;
    logic [`NUM_RECFG*`RECFG_OUT_W-1:0]   recfg_out;
  } state_t;
endpackage : xcvr_ctrl_pkg

// ==== testbench/mgmt_host.sv ====
// host model on the management bus
`timescale 1ns/1ns
`include "xcvr_ctrl_defines.svh"
module mgmt_host (
  // clock
  input  wire logic               clk,
  // management bus
  output      logic [`ADDR_W-1:0] address,
  output      logic               read,
  output      logic               write,
  output      logic [`DATA_W-1:0] writedata,
  input  wire logic [`DATA_W-1:0] readdata,
  input  wire logic               waitrequest
);
  initial begin
    {address, read, write, writedata} = '0;
  end
  // gap cycle after each write keeps one strobe change per step
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    {address, writedata, write} <= {a, d, 1'b1};
    @(posedge clk);
    {writedata, write} <= {~d, 1'b0};
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d, output logic ok);
    ok = 1'b0;
    {address, read} <= {a, 1'b1};
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge clk);
      ok = (waitrequest === 1'b0);
    end
    d = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask : rd
endmodule : mgmt_host

// ==== testbench/transceiver_pma_pcs_control_regs_tb_top.sv ====
// self-checking bench of the control bank
`timescale 1ns/1ns
`include "xcvr_ctrl_defines.svh"
module transceiver_pma_pcs_control_regs_tb_top
  import xcvr_ctrl_pkg::*;
;
  localparam int SW = `SLIP_W;
  localparam int IW = `RECFG_IN_W;
  localparam int OW = `RECFG_OUT_W;
  logic                 clk, resetn, mgmt_read, mgmt_write, mgmt_waitrequest;
  logic [`ADDR_W-1:0]   mgmt_address;
  logic [`DATA_W-1:0]   mgmt_writedata, mgmt_readdata;
  ch_vec_t              rx_signal_present_in, cdr_locked_data_in, cdr_locked_reference_in;
  ch_vec_t              rx_fifo_error_in, tx_fifo_error_in, serial_loopback, cdr_lock_data;
  ch_vec_t              cdr_lock_reference, cdr_auto_mode, tx_invert, rx_invert, rx_slip_pulse;
  ch_vec_t              rx_byte_reverse, rx_bit_reverse, rx_align_enable;
  logic [`NUM_CH*SW-1:0] rx_slipped_in, tx_slip_count;
  logic [`NUM_RECFG*IW-1:0] reconfig_bus_in;
  logic [`NUM_RECFG*OW-1:0] reconfig_bus_out;
  int                   error_cnt = 0, comparisons = 0, pulse_cnt = 0;
  transceiver_pma_pcs_control_regs dut (.clk, .resetn, .mgmt_address, .mgmt_read, .mgmt_write,
    .mgmt_writedata, .mgmt_readdata, .mgmt_waitrequest, .rx_signal_present_in,
    .cdr_locked_data_in, .cdr_locked_reference_in, .rx_slipped_in, .rx_fifo_error_in,
    .tx_fifo_error_in, .serial_loopback, .cdr_lock_data, .cdr_lock_reference, .cdr_auto_mode,
    .tx_slip_count, .tx_invert, .rx_invert, .rx_slip_pulse, .rx_byte_reverse, .rx_bit_reverse,
    .rx_align_enable, .reconfig_bus_in, .reconfig_bus_out);
  mgmt_host host (.clk, .address(mgmt_address), .read(mgmt_read), .write(mgmt_write),
    .writedata(mgmt_writedata), .readdata(mgmt_readdata), .waitrequest(mgmt_waitrequest));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // lane 2 pulses weigh 1, a pulse anywhere else 100
  always @(posedge clk) begin
    if (rx_slip_pulse === ch_vec_t'(4)) pulse_cnt++;
    else if (rx_slip_pulse !== '0) pulse_cnt += 100;
  end
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t read %h want %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t pin %h want %h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic conclude();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    host.rd(a, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH %0t read wait expired", $time);
      conclude();
    end
    chk_rd(d, exp);
  endtask : rd_chk
  initial begin
    logic [31:0] v, e [3], tv [`NUM_CH+1], xv [`NUM_CH+1];
    logic [8:0]  o [3];
    {resetn, rx_signal_present_in, cdr_locked_data_in, cdr_locked_reference_in} = '0;
    {rx_slipped_in, rx_fifo_error_in, tx_fifo_error_in, reconfig_bus_in} = '0;
    v = $urandom(32'h4b38);
    repeat (4) @(posedge clk);
    chk_pin(cdr_auto_mode, {`NUM_CH{1'b1}});
    resetn <= 1'b1;
    @(posedge clk);
    o = '{`OFS_LOOPBACK, `OFS_LTD_REQ, `OFS_LTR_REQ};
    for (int r = 0; r < 6; r++) begin
      e[r%3] = (r < 3) ? '1 : $urandom;
      host.wr(o[r%3], e[r%3]);
      rd_chk(o[r%3], 32'(ch_vec_t'(e[r%3])));
      v = r%3 == 0 ? serial_loopback : r%3 == 1 ? cdr_lock_data : cdr_lock_reference;
      chk_pin(v, ch_vec_t'(e[r%3]));
    end
    chk_pin(cdr_auto_mode, ch_vec_t'(~(e[1] | e[2])));
    {rx_signal_present_in, cdr_locked_data_in, cdr_locked_reference_in, rx_fifo_error_in}
      <= (4*`NUM_CH)'($urandom);
    rx_slipped_in <= (`NUM_CH*SW)'($urandom);
    reconfig_bus_in <= (`NUM_RECFG*IW)'({11{$urandom}});
    repeat (3) @(posedge clk);
    for (int p = 0; p < `NUM_RECFG; p++) begin
      chk_pin(reconfig_bus_out[p*OW +: OW], reconfig_bus_in[p*IW +: OW]);
    end
    o = '{`OFS_SIG_PRESENT, `OFS_LTD_STAT, `OFS_LTR_STAT};
    e = '{32'(rx_signal_present_in), 32'(cdr_locked_data_in), 32'(cdr_locked_reference_in)};
    for (int r = 0; r < 3; r++) begin
      host.wr(o[r], '1);
      rd_chk(o[r], e[r]);
    end
    // last pass selects a lane that does not exist
    for (int l = 0; l <= `NUM_CH; l++) begin
      tv[l] = $urandom;
      xv[l] = $urandom;
      v = l < `NUM_CH ? 32'h3f : 32'h0;
      host.wr(`OFS_LANE_SEL, l);
      host.wr(`OFS_TX_CTRL, tv[l]);
      host.wr(`OFS_RX_POL, xv[l] >> 3);
      host.wr(`OFS_RX_ORDER, xv[l] & 32'h7);
      rd_chk(`OFS_TX_CTRL, tv[l] & v);
      rd_chk(`OFS_RX_POL, xv[l][3] & v);
      rd_chk(`OFS_RX_ORDER, xv[l] & v & 32'h7);
      rd_chk(`OFS_RX_ALIGN, v & {rx_slipped_in[l*SW +: SW], rx_fifo_error_in[l]});
    end
    for (int l = 0; l < `NUM_CH; l++) begin
      chk_pin({tx_slip_count[l*SW +: SW], tx_invert[l]}, tv[l][5:0]);
      chk_pin({rx_invert[l], rx_byte_reverse[l], rx_bit_reverse[l],
               rx_align_enable[l]}, xv[l][3:0]);
    end
    host.wr(`OFS_LANE_SEL, 2);
    v = pulse_cnt;
    // rise, hold, drop, rise again
    host.wr(`OFS_RX_ORDER, 32'h8);
    host.wr(`OFS_RX_ORDER, 32'h8);
    host.wr(`OFS_RX_ORDER, 32'h0);
    host.wr(`OFS_RX_ORDER, 32'h8);
    @(posedge clk);
    chk_pin(pulse_cnt - v, 2);
    host.wr(`OFS_LANE_SEL, 1);
    host.wr(`OFS_TX_FIFO, 32'h1);
    rd_chk(`OFS_TX_FIFO, 32'h0);
    tx_fifo_error_in <= ch_vec_t'(2);
    @(posedge clk);
    tx_fifo_error_in <= '0;
    repeat (3) @(posedge clk);
    host.wr(`OFS_TX_FIFO, 32'hffff_fffe);
    rd_chk(`OFS_TX_FIFO, 32'h1);
    host.wr(`OFS_TX_FIFO, 32'h1);
    rd_chk(`OFS_TX_FIFO, 32'h0);
    rd_chk(9'h000, 32'h0);
    rd_chk(9'h062, 32'h0);
    conclude();
  end
endmodule : transceiver_pma_pcs_control_regs_tb_top

// ==== testbench/xcvr_ctrl_chk.sv ====
// assertions on the control bank ports
`timescale 1ns/1ns
`include "xcvr_ctrl_defines.svh"
module xcvr_ctrl_chk
  import xcvr_ctrl_pkg::*;
(
  // clock, reset and management bus
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic [`ADDR_W-1:0] mgmt_address,
  input wire logic               mgmt_read,
  input wire logic               mgmt_write,
  input wire logic [`DATA_W-1:0] mgmt_writedata,
  input wire logic [`DATA_W-1:0] mgmt_readdata,
  input wire logic               mgmt_waitrequest,
  // channel controls and reconfiguration ports
  input wire logic [`NUM_CH-1:0] serial_loopback,
  input wire logic [`NUM_CH-1:0] cdr_lock_data,
  input wire logic [`NUM_CH-1:0] cdr_lock_reference,
  input wire logic [`NUM_CH-1:0] cdr_auto_mode,
  input wire logic [`NUM_CH-1:0] rx_slip_pulse,
  input wire logic [`NUM_RECFG*`RECFG_IN_W-1:0]  reconfig_bus_in,
  input wire logic [`NUM_RECFG*`RECFG_OUT_W-1:0] reconfig_bus_out
);
  localparam int P = `NUM_CH;
  logic                    wr_ok;
  logic                    slip_wr_q;
  logic [`RECFG_OUT_W-1:0] pll_q;
  assign wr_ok = mgmt_write & ~mgmt_read;
  // pll port sits last, so a port index slip shows up there
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slip_wr_q <= 1'b0;
      pll_q     <= '0;
    end else begin
      slip_wr_q <= wr_ok && mgmt_address == `OFS_RX_ORDER && mgmt_writedata[`BIT_RX_SLIP];
      pll_q     <= reconfig_bus_in[P*`RECFG_IN_W +: `RECFG_OUT_W];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_rd_start; mgmt_read && mgmt_waitrequest; endsequence
  sequence s_wr(a); wr_ok && mgmt_address == a; endsequence
  a_wait_one: assert property (s_rd_start |=> !mgmt_waitrequest)
    else $error("read stalled too long");
  a_write_nowait: assert property (wr_ok |-> !mgmt_waitrequest)
    else $error("write stalled");
  a_loopback_write: assert property (s_wr(`OFS_LOOPBACK) |=>
    serial_loopback == ch_vec_t'($past(mgmt_writedata))) else $error("loopback");
  a_auto_mode: assert property (cdr_auto_mode == ~(cdr_lock_data | cdr_lock_reference))
    else $error("auto mode");
  a_slip_single: assert property (|rx_slip_pulse |=> rx_slip_pulse == '0)
    else $error("slip pulse too long");
  a_slip_cause: assert property (|rx_slip_pulse |-> slip_wr_q)
    else $error("slip without write");
  a_pll_echo: assert property (reconfig_bus_out[P*`RECFG_OUT_W +: `RECFG_OUT_W] == pll_q)
    else $error("pll port echo");
  a_unmapped_zero: assert property (s_rd_start ##0 mgmt_address == 9'h000 |=>
    mgmt_readdata == '0) else $error("unmapped read");
endmodule : xcvr_ctrl_chk
bind transceiver_pma_pcs_control_regs xcvr_ctrl_chk u_chk (.clk, .resetn, .mgmt_address,
  .mgmt_read, .mgmt_write, .mgmt_writedata, .mgmt_readdata, .mgmt_waitrequest, .serial_loopback,
  .cdr_lock_data, .cdr_lock_reference, .cdr_auto_mode, .rx_slip_pulse, .reconfig_bus_in,
  .reconfig_bus_out);
